//--- hw/nvws_pkg.sv
// Package of constants and types for the non-volatile write sequencer
package nvws_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [5:0] OFS_ADDR_LOW = 6'h00;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h04;
  localparam logic [5:0] OFS_DATA_LOW = 6'h08;
  localparam logic [5:0] OFS_DATA_HIGH = 6'h0C;
  localparam logic [5:0] OFS_CONTROL = 6'h10;
  localparam logic [5:0] OFS_KEY = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_PROTECT = 6'h1C;
  // Control and status field positions
  localparam int BIT_READ = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_WEN = 2;
  localparam int BIT_WERR = 3;
  localparam int BIT_PSEL = 7;
  localparam int BIT_DONE = 0;
  localparam int BIT_HALT = 1;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int NV_WRITE_MS = 4;
  localparam int NV_WRITE_CYCLES = CLK_HZ / 1000 * NV_WRITE_MS;
  localparam int EE_WRITE_CYCLES = 16;
  localparam int SETUP_CYCLES = 2;
  localparam int PREAD_CYCLES = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PROTECT = 2'h0;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREAD,
    ST_SETUP,
    ST_BUSY
  } nvws_state_t;
  // Memory-side request grouped as one carrier
  typedef struct packed {
    logic ee_wr;
    logic pg_wr_block;
    logic [12:0] addr;
  } nvws_req_t;
endpackage

//--- hw/nvws_timer.sv
// Down-counter that times the byte and block write intervals
`timescale 1ns/1ps
module nvws_timer #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  // Status
  output logic expired
);
  initial begin
    if (WIDTH < 2) $error("nvws_timer width too small");
  end
  logic [WIDTH-1:0] remain;
  // Expiry is a one-cycle pulse on reaching one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end
  assign expired = (remain == {{(WIDTH-1){1'b0}}, 1'b1}) && !load;
endmodule

//--- hw/nvws_top.sv
// AXI4-Lite register block and write sequencer for data EEPROM and program flash
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module nvws_top #(
  parameter int WRITE_CYCLES = nvws_pkg::NV_WRITE_CYCLES,
  parameter int EE_CYCLES = nvws_pkg::EE_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset cause: high while the reset is a master-clear or watchdog one
  input wire logic abort_reset,
  // Core halt
  output logic cpu_halt
);
  initial begin
    if (WRITE_CYCLES < 2 || WRITE_CYCLES > 262143) $error("WRITE_CYCLES out of range");
    if (EE_CYCLES < 2 || EE_CYCLES > 262143) $error("EE_CYCLES out of range");
  end
  // Registers
  logic [7:0] nv_addr_low, nv_data_low;
  logic [4:0] nv_addr_high;
  logic [5:0] nv_data_high;
  logic program_space_select, write_enable_gate, aborted_commit_flag;
  logic wr_start, rd_start, nv_done_flag, write_busy, was_busy, pread_load;
  logic [1:0] flash_protect_field, key_stage;
  nvws_pkg::nvws_state_t state;
  // Storage arrays for data EEPROM and program flash
  logic [7:0] ee_mem [0:255];
  logic [13:0] pg_mem [0:8191];
  logic [13:0] blk_buf [0:3];
  logic [1:0] next_slot;
  nvws_pkg::nvws_req_t req;
  // AXI write path: latch address and data independently
  logic aw_held, w_held, wr_fire;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end
  // Write response; unmapped offsets answer SLVERR
  logic wr_map;
  assign wr_map = aw_addr <= nvws_pkg::OFS_PROTECT && aw_addr[1:0] == 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Decoded register writes, low byte lane only
  logic wr_ok, wr_ctl, wr_key;
  logic [7:0] wb;
  assign wr_ok = wr_fire && w_strb[0];
  assign wb = w_data[7:0];
  assign wr_ctl = wr_ok && aw_addr == nvws_pkg::OFS_CONTROL;
  assign wr_key = wr_ok && aw_addr == nvws_pkg::OFS_KEY;
  assign write_busy = wr_start;
  // Unlock key tracker; any other register write disarms it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_stage <= 2'h0;
    end else if (wr_key && wb == nvws_pkg::KEY_FIRST) begin
      key_stage <= 2'h1;
    end else if (wr_key && wb == nvws_pkg::KEY_SECOND && key_stage == 2'h1) begin
      key_stage <= 2'h2;
    end else if (wr_ok) begin
      key_stage <= 2'h0;
    end
  end
  // Start requests: write needs enable gate and armed unlock
  logic want_write, want_read, seq_ok, pg_allowed;
  logic [1:0] low2;
  assign want_write = wr_ctl && wb[nvws_pkg::BIT_WRITE] && !wr_start
    && write_enable_gate && key_stage == 2'h2;
  assign want_read = wr_ctl && wb[nvws_pkg::BIT_READ] && !rd_start && !wr_start;
  assign low2 = nv_addr_low[1:0];
  // Protect field: 0 none, 1 top half, 2 top three quarters, 3 everything
  always_comb begin
    case (flash_protect_field)
      2'h0: pg_allowed = 1'b1;
      2'h1: pg_allowed = !nv_addr_high[4];
      2'h2: pg_allowed = nv_addr_high[4:3] == 2'h0;
      default: pg_allowed = 1'b0;
    endcase
  end
  assign seq_ok = pg_allowed && low2 == next_slot;
  // Control register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_space_select <= 1'b0;
      write_enable_gate <= 1'b0;
    end else if (wr_ctl) begin
      write_enable_gate <= wb[nvws_pkg::BIT_WEN];
      if (!write_busy) begin
        program_space_select <= wb[nvws_pkg::BIT_PSEL];
      end
    end
  end
  // Aborted flag: caught after an abort reset when a write was cut short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aborted_commit_flag <= 1'b0;
    end else if (was_busy) begin
      aborted_commit_flag <= 1'b1;
    end else if (wr_ctl && !wb[nvws_pkg::BIT_WERR]) begin
      aborted_commit_flag <= 1'b0;
    end
  end
  // Busy marker survives a reset tagged as abort so the flag can be raised
  always_ff @(posedge aclk) begin
    if (!aresetn && abort_reset) begin
      was_busy <= write_busy || was_busy;
    end else begin
      was_busy <= 1'b0;
    end
  end
  // Sequencer and timer
  logic tmr_load, tmr_done, pg_last;
  logic [17:0] tmr_count;
  logic [1:0] setup_cnt;
  nvws_timer #(.WIDTH(18)) i_nvws_timer (
    .aclk(aclk), .aresetn(aresetn),
    .load(tmr_load), .count(tmr_count),
    .expired(tmr_done)
  );
  assign tmr_load = state == nvws_pkg::ST_SETUP && setup_cnt == 2'h0 && pg_last
    || want_write && !program_space_select;
  assign tmr_count = program_space_select ? WRITE_CYCLES[17:0] : EE_CYCLES[17:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= nvws_pkg::ST_IDLE;
      setup_cnt <= 2'h0;
      pg_last <= 1'b0;
      wr_start <= 1'b0;
      rd_start <= 1'b0;
      next_slot <= 2'h0;
    end else begin
      case (state)
        nvws_pkg::ST_IDLE: begin
          if (want_write && !program_space_select) begin
            wr_start <= 1'b1;
            state <= nvws_pkg::ST_BUSY;
          end else if (want_write && seq_ok) begin
            wr_start <= 1'b1;
            pg_last <= low2 == 2'h3;
            setup_cnt <= 2'(nvws_pkg::SETUP_CYCLES - 1);
            state <= nvws_pkg::ST_SETUP;
          end else if (want_write) begin
            next_slot <= 2'h0;
          end else if (want_read && program_space_select) begin
            rd_start <= 1'b1;
            setup_cnt <= 2'(nvws_pkg::PREAD_CYCLES - 1);
            state <= nvws_pkg::ST_PREAD;
          end
        end
        nvws_pkg::ST_PREAD: begin
          if (setup_cnt == 2'h0) begin
            rd_start <= 1'b0;
            state <= nvws_pkg::ST_IDLE;
          end else begin
            setup_cnt <= setup_cnt - 2'h1;
          end
        end
        nvws_pkg::ST_SETUP: begin
          if (setup_cnt != 2'h0) begin
            setup_cnt <= setup_cnt - 2'h1;
          end else if (pg_last) begin
            state <= nvws_pkg::ST_BUSY;
          end else begin
            wr_start <= 1'b0;
            next_slot <= next_slot + 2'h1;
            state <= nvws_pkg::ST_IDLE;
          end
        end
        nvws_pkg::ST_BUSY: begin
          if (tmr_done) begin
            wr_start <= 1'b0;
            next_slot <= 2'h0;
            pg_last <= 1'b0;
            state <= nvws_pkg::ST_IDLE;
          end
        end
        default: state <= nvws_pkg::ST_IDLE;
      endcase
    end
  end
  // Halt covers read stall, setup and block write; resume picks up afterwards
  assign cpu_halt = state == nvws_pkg::ST_PREAD || state == nvws_pkg::ST_SETUP
    || state == nvws_pkg::ST_BUSY && pg_last;
  // Completion event for a write or a block commit
  logic write_end, buf_end;
  assign write_end = state == nvws_pkg::ST_BUSY && tmr_done;
  assign buf_end = state == nvws_pkg::ST_SETUP && setup_cnt == 2'h0 && !pg_last;
  assign req.ee_wr = write_end && !pg_last;
  assign req.pg_wr_block = write_end && pg_last;
  assign req.addr = {nv_addr_high, nv_addr_low};
  // Done flag: set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_done_flag <= 1'b0;
    end else if (write_end || buf_end) begin
      nv_done_flag <= 1'b1;
    end else if (wr_ok && aw_addr == nvws_pkg::OFS_STATUS && wb[nvws_pkg::BIT_DONE]) begin
      nv_done_flag <= 1'b0;
    end
  end
  // Memory arrays: buffer fills per word, block programs on the last
  always_ff @(posedge aclk) begin
    if (buf_end || req.pg_wr_block) begin
      blk_buf[low2] <= {nv_data_high, nv_data_low};
    end
    if (req.ee_wr) begin
      ee_mem[nv_addr_low] <= nv_data_low;
    end
    if (req.pg_wr_block) begin
      for (int i = 0; i < 3; i++) begin
        pg_mem[{req.addr[12:2], 2'(i)}] <= blk_buf[i];
      end
      pg_mem[req.addr] <= {nv_data_high, nv_data_low};
    end
  end
  // Address, data and protect registers; program reads load the data pair, byte reads the low data byte
  assign pread_load = state == nvws_pkg::ST_PREAD && setup_cnt == 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_protect_field <= nvws_pkg::RST_PROTECT;
      // Abort resets keep address and data so firmware can retry the write
      if (!abort_reset) begin
        nv_addr_low <= nvws_pkg::RST_BYTE;
        nv_addr_high <= 5'h00;
        nv_data_low <= nvws_pkg::RST_BYTE;
        nv_data_high <= 6'h00;
      end
    end else begin
      if (wr_ok && aw_addr == nvws_pkg::OFS_ADDR_LOW && !write_busy) nv_addr_low <= wb;
      if (wr_ok && aw_addr == nvws_pkg::OFS_ADDR_HIGH && !write_busy) nv_addr_high <= wb[4:0];
      if (wr_ok && aw_addr == nvws_pkg::OFS_PROTECT) flash_protect_field <= wb[1:0];
      if (pread_load) begin
        nv_data_low <= pg_mem[req.addr][7:0];
        nv_data_high <= pg_mem[req.addr][13:8];
      end else if (want_read && !program_space_select && state == nvws_pkg::ST_IDLE) begin
        nv_data_low <= ee_mem[nv_addr_low];
      end else begin
        if (wr_ok && aw_addr == nvws_pkg::OFS_DATA_LOW && !write_busy) nv_data_low <= wb;
        if (wr_ok && aw_addr == nvws_pkg::OFS_DATA_HIGH && !write_busy) nv_data_high <= wb[5:0];
      end
    end
  end
  // Read channel
  logic [31:0] rd_val;
  logic rd_map;
  always_comb begin
    rd_map = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      nvws_pkg::OFS_ADDR_LOW: rd_val = {24'h000000, nv_addr_low};
      nvws_pkg::OFS_ADDR_HIGH: rd_val = {27'h0000000, nv_addr_high};
      nvws_pkg::OFS_DATA_LOW: rd_val = {24'h000000, nv_data_low};
      nvws_pkg::OFS_DATA_HIGH: rd_val = {26'h0000000, nv_data_high};
      nvws_pkg::OFS_CONTROL: rd_val = {24'h000000, program_space_select, 3'h0,
        aborted_commit_flag, write_enable_gate, wr_start, rd_start};
      nvws_pkg::OFS_KEY: rd_val = 32'h00000000;
      nvws_pkg::OFS_STATUS: rd_val = {30'h00000000, cpu_halt, nv_done_flag};
      nvws_pkg::OFS_PROTECT: rd_val = {30'h00000000, flash_protect_field};
      default: rd_map = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Checks
  chk_key_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wr_start) |-> $past(key_stage) == 2'h2 && $past(write_enable_gate))
    else $error("write started without unlock or enable");
  chk_wen_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    write_enable_gate && !wr_ctl |=> write_enable_gate)
    else $error("write enable changed without a control write");
  chk_done_set: assert property (@(posedge aclk) disable iff (!aresetn)
    write_end |=> !wr_start && nv_done_flag)
    else $error("completion did not clear start and set done");
  sequence s_pread_go;
    want_read && program_space_select && state == nvws_pkg::ST_IDLE;
  endsequence
  chk_pread_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pread_go |=> cpu_halt [*2] ##1 !cpu_halt && !rd_start)
    else $error("program read stall not two cycles");
  sequence s_pg_start;
    state == nvws_pkg::ST_IDLE && want_write && program_space_select && seq_ok;
  endsequence
  chk_setup_two: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pg_start |=> cpu_halt [*2])
    else $error("program write setup not two cycles");
  chk_psel_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    write_busy |=> $stable(program_space_select))
    else $error("space select changed during write");
  chk_ee_read: assert property (@(posedge aclk) disable iff (!aresetn)
    want_read && !program_space_select && state == nvws_pkg::ST_IDLE
    |=> nv_data_low == ee_mem[$past(nv_addr_low)])
    else $error("data read not returned next cycle");
  chk_bad_slot: assert property (@(posedge aclk) disable iff (!aresetn)
    state == nvws_pkg::ST_IDLE && want_write && program_space_select && !seq_ok
    |=> !wr_start)
    else $error("out-of-order or protected write accepted");
  chk_start_held: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_start && !write_end && !buf_end |=> wr_start)
    else $error("start bit cleared before completion");
endmodule

//--- tb/nvws_top_tb.sv
// Self-checking testbench for the non-volatile write sequencer
`timescale 1ns/1ps
module nvws_top_tb;
  localparam int WCYC = 20;
  localparam int ECYC = 16;
  localparam logic [5:0] A_AL = nvws_pkg::OFS_ADDR_LOW;
  localparam logic [5:0] A_DL = nvws_pkg::OFS_DATA_LOW;
  localparam logic [5:0] A_DH = nvws_pkg::OFS_DATA_HIGH;
  localparam logic [5:0] A_CT = nvws_pkg::OFS_CONTROL;
  localparam logic [5:0] A_KY = nvws_pkg::OFS_KEY;
  localparam logic [5:0] A_ST = nvws_pkg::OFS_STATUS;
  // Clock, reset and bus input signals, all defined at time zero
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic abort_reset = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_halt;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, v;
  int errors = 0;
  int num_checks = 0;
  int halt_cnt = 0;
  logic [13:0] words [4] = '{14'h3A5C, 14'h0123, 14'h2BCD, 14'h1F0E};

  nvws_top #(.WRITE_CYCLES(WCYC), .EE_CYCLES(ECYC)) i_nvws_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .abort_reset(abort_reset), .cpu_halt(cpu_halt)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // Halt length is measured in clock cycles, cleared by the bench between operations
  always @(posedge aclk) begin
    if (cpu_halt === 1'b1) halt_cnt <= halt_cnt + 1;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    errors++;
    $display("BAD %s expected answer seen none", what);
    give_verdict();
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Write cycle: address and data offered together, each released when taken
  task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    // Spare edge so back-to-back calls never drive a signal twice in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (++n > 50) hang("write response");
    end
  endtask

  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ar_ok;
    int n;
    ar_ok = 0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (ar_ok && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (++n > 50) hang("read data");
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] rs;
    axw(a, d, rs);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] rs;
    axr(a, d, rs);
    chk(what, d, exp);
  endtask

  // Key pair followed directly by the control write
  task automatic unlock(input logic [31:0] ctrl);
    wr(A_KY, 32'h55);
    wr(A_KY, 32'hAA);
    wr(A_CT, ctrl);
  endtask

  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    n = 0;
    do begin
      axr(A_CT, d, rs);
      if (++n > 200) hang("write completion");
    end while (d[1] !== 1'b0 || cpu_halt !== 1'b0);
  endtask

  task automatic ee_write(input logic [7:0] a, input logic [7:0] d, input bit meddle);
    wr(A_AL, {24'h0, a});
    wr(A_DL, {24'h0, d});
    wr(A_CT, 32'h04);
    unlock(32'h06);
    if (meddle) begin
      wr(A_CT, 32'h00);
      rd(A_CT, 32'h02, "start kept after enable cleared");
      wr(A_DL, 32'hFF);
    end
    wait_idle();
    rd(A_CT, meddle ? 32'h00 : 32'h04, "control after byte write");
    rd(A_ST, 32'h01, "done flag set");
    rd(A_ST, 32'h01, "done flag sticky");
    wr(A_ST, 32'h01);
    rd(A_ST, 32'h00, "done flag cleared");
  endtask

  // Buffered program word; the last slot is meddled with while busy
  task automatic prog_word(input logic [7:0] a, input logic [13:0] w, input bit last);
    wr(A_AL, {24'h0, a});
    wr(A_DL, {24'h0, w[7:0]});
    wr(A_DH, {26'h0, w[13:8]});
    wr(A_CT, 32'h84);
    halt_cnt = 0;
    unlock(32'h86);
    if (last) begin
      wr(A_CT, 32'h06);
      rd(A_CT, 32'h86, "space select frozen while busy");
      rd(A_ST, 32'h02, "halt status while busy");
    end
    wait_idle();
    chk("halt length", halt_cnt, last ? WCYC + 2 : 2);
    rd(A_ST, 32'h01, "done after program word");
    wr(A_ST, 32'h01);
  endtask

  task automatic prog_read(input logic [7:0] a, input logic [13:0] w);
    wr(A_AL, {24'h0, a});
    halt_cnt = 0;
    wr(A_CT, 32'h81);
    repeat (3) @(posedge aclk);
    chk("read stall", halt_cnt, nvws_pkg::PREAD_CYCLES);
    rd(A_DL, {24'h0, w[7:0]}, "program word low");
    rd(A_DH, {26'h0, w[13:8]}, "program word high");
  endtask

  // Start attempt that must be dropped without halting or flagging
  task automatic dropped(input logic [7:0] a, input string what);
    wr(A_AL, {24'h0, a});
    wr(A_DL, 32'h3C);
    halt_cnt = 0;
    unlock(32'h86);
    repeat (4) @(posedge aclk);
    chk(what, halt_cnt, 0);
    rd(A_CT, 32'h84, what);
    rd(A_ST, 32'h00, what);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_CT, 32'h00, "control after reset");
    rd(A_ST, 32'h00, "status after reset");
    rd(A_KY, 32'h00, "key port");
    axr(6'h20, v, r);
    chk("unmapped read resp", r, 2'h2);
    axw(6'h02, 32'h1, r);
    chk("unaligned write resp", r, 2'h2);
    // A write without byte lane 0 must leave the register alone
    s_axi_wstrb <= 4'hE;
    wr(A_AL, 32'h77);
    s_axi_wstrb <= 4'hF;
    rd(A_AL, 32'h00, "write without lane 0");
    // Start refused while writes disabled
    unlock(32'h02);
    rd(A_CT, 32'h00, "start without enable");
    // Broken key sequences
    wr(A_CT, 32'h04);
    wr(A_KY, 32'h55);
    wr(A_AL, 32'h12);
    wr(A_KY, 32'hAA);
    wr(A_CT, 32'h06);
    rd(A_CT, 32'h04, "interrupted unlock");
    wr(A_KY, 32'hAA);
    wr(A_KY, 32'h55);
    wr(A_CT, 32'h06);
    rd(A_CT, 32'h04, "swapped keys");
    ee_write(8'h12, 8'h5A, 1'b0);
    ee_write(8'h13, 8'hA7, 1'b1);
    foreach (words[i]) begin
      wr(A_AL, 32'h12 + i[31:0] % 2);
      wr(A_CT, 32'h01);
      rd(A_DL, (i % 2) ? 32'hA7 : 32'h5A, "byte read");
      rd(A_CT, 32'h00, "read start self-clears");
    end
    wr(A_DH, 32'h00);
    foreach (words[i]) prog_word(8'h40 + i[7:0], words[i], i == 3);
    foreach (words[i]) prog_read(8'h40 + i[7:0], words[i]);
    dropped(8'h41, "out of order slot");
    prog_read(8'h41, words[1]);
    wr(nvws_pkg::OFS_PROTECT, 32'h3);
    rd(nvws_pkg::OFS_PROTECT, 32'h3, "protect field");
    dropped(8'h80, "protected segment");
    wr(nvws_pkg::OFS_PROTECT, 32'h0);
    // Master-clear reset in mid-write
    wr(A_AL, 32'h33);
    wr(A_DL, 32'hC3);
    wr(A_CT, 32'h04);
    unlock(32'h06);
    aresetn <= 1'b0;
    abort_reset <= 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    abort_reset <= 1'b0;
    @(posedge aclk);
    rd(A_CT, 32'h08, "aborted flag");
    rd(A_AL, 32'h33, "address kept");
    rd(A_DL, 32'hC3, "data kept");
    wr(A_CT, 32'h00);
    rd(A_CT, 32'h00, "aborted flag cleared");
    give_verdict();
  end
endmodule
